// >>> rtl/alfb_pkg.sv
package alfb_pkg;

	localparam int unsigned ALFB_CLK_HZ = 250_000_000;

	// register byte offsets
	localparam logic [3:0] ALFB_OFS_LCW  = 4'h0;
	localparam logic [3:0] ALFB_OFS_SSW  = 4'h4;
	localparam logic [3:0] ALFB_OFS_STAT = 4'h8;

	// line_control_word fields
	localparam int ALFB_LCW_SEL_LSB  = 9;
	localparam int ALFB_LCW_DATA_LSB = 11;
	localparam int ALFB_LCW_STB_BIT  = 15;

	// secondary_select_word fields
	localparam int ALFB_SSW_LINE_LSB = 0;
	localparam int ALFB_SSW_REG_LSB  = 8;

	// positions inside the four data bits (bit 11 is position 0)
	localparam int ALFB_FMT_LEN_LSB  = 0;
	localparam int ALFB_FMT_TWO_STOP = 2;
	localparam int ALFB_FMT_PAR_EN   = 3;
	localparam int ALFB_PRI_EVEN     = 1;

	// status word fields
	localparam int ALFB_STAT_FMT_LSB = 0;
	localparam int ALFB_STAT_SPD_LSB = 4;
	localparam int ALFB_STAT_EVEN    = 8;

	localparam logic [3:0]  ALFB_RST_NIBBLE = 4'h0;
	localparam logic [31:0] ALFB_RST_WORD   = 32'h0000_0000;

	// selection code as {bit 10, bit 09}
	typedef enum logic [1:0] {
		ALFB_SEL_PRIMARY = 2'b00,
		ALFB_SEL_FORMAT  = 2'b01,
		ALFB_SEL_SPEED   = 2'b10,
		ALFB_SEL_MAINT   = 2'b11
	} alfb_sel_t;

	typedef enum logic {
		ALFB_BUS_IDLE = 1'b0,
		ALFB_BUS_ACK  = 1'b1
	} alfb_bus_t;

	// rates in tenths of a baud, index is the speed code
	localparam int unsigned ALFB_BAUD_X10 [16] = '{
		500, 750, 1100, 1345, 1500, 3000, 6000, 12000,
		18000, 20000, 24000, 36000, 48000, 72000, 96000, 384000
	};

	localparam int ALFB_CYC_W = 23;

	typedef struct packed {
		logic [3:0]            data_bits;
		logic [1:0]            stop_bits;
		logic                  parity_en;
		logic                  even_parity;
		logic [3:0]            speed_code;
		logic [ALFB_CYC_W-1:0] bit_cycles;
	} alfb_line_cfg_t;

	// clock cycles per bit, rounded to nearest
	function automatic logic [ALFB_CYC_W-1:0] alfb_bit_cycles(input logic [3:0] code);
		longint unsigned num;
		longint unsigned b;
		num = longint'(ALFB_CLK_HZ) * 64'd10;
		b   = longint'(ALFB_BAUD_X10[code]);
		return ALFB_CYC_W'((num + b / 64'd2) / b);
	endfunction : alfb_bit_cycles

endpackage : alfb_pkg

// >>> rtl/alfb_line_cfg.sv
`timescale 1ns/100ps
// Summary of operation
// - selection code binary 01 plus strobe loads the selected line's format setting.
// - format bits 12,11 give character length 5, 6, 7 or 8 bits.
// - format bit 13 set gives two stop bits, clear gives one.
// - format bit 14 enables parity generation and checking; sense from even-parity setting.
// - writing bit 15 copies bits 11-14 into selected format or speed setting, bit 12 into even-parity setting, nothing for code 11; bit 15 self-clears.
// - strobe may come in the same write as data and selection code.
// - selection code binary 10 plus strobe loads the selected line's speed code.
// - speed codes 0000-0111 select 50 to 1200 baud, common to both directions.
// - speed codes 1000-1111 select 1800 to 38400 baud.
// - initialize clears all per-line settings and the selection code.
// - even-parity setting picks even when set, odd when clear.
module alfb_line_cfg #(
	parameter int LINES = 16
) (
	input  wire logic                         ref_clk,
	input  wire logic                         nrst,
	input  wire logic [3:0]                   avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [31:0]                  avs_writedata,
	input  wire logic [3:0]                   avs_byteenable,
	output logic [31:0]                       avs_readdata,
	output logic                              avs_waitrequest,
	output alfb_pkg::alfb_line_cfg_t [LINES-1:0] line_cfg
);

	// the line field of the select word is four bits wide, so more lines cannot be reached
	if (LINES < 1 || LINES > 16)
	begin : g_bad_lines
		$error("alfb_line_cfg: LINES must be 1 to 16");
	end

	// bus handshake
	alfb_pkg::alfb_bus_t bus_q;
	alfb_pkg::alfb_bus_t bus_d;
	logic                wait_q;
	logic [31:0]         rdata_q;
	logic [31:0]         rdata_d;

	wire req      = avs_read | avs_write;
	wire accept   = req & (bus_q == alfb_pkg::ALFB_BUS_ACK);
	wire wr_acc   = accept & avs_write;
	wire aligned  = (avs_address[1:0] == 2'b00);
	wire hit_lcw  = aligned & (avs_address == alfb_pkg::ALFB_OFS_LCW);
	wire hit_ssw  = aligned & (avs_address == alfb_pkg::ALFB_OFS_SSW);
	wire hit_stat = aligned & (avs_address == alfb_pkg::ALFB_OFS_STAT);

	always_comb
	begin
		case (bus_q)
			alfb_pkg::ALFB_BUS_IDLE: bus_d = req ? alfb_pkg::ALFB_BUS_ACK : alfb_pkg::ALFB_BUS_IDLE;
			alfb_pkg::ALFB_BUS_ACK:  bus_d = alfb_pkg::ALFB_BUS_IDLE;
			default:                 bus_d = alfb_pkg::ALFB_BUS_IDLE;
		endcase
	end

	// waitrequest falls for exactly the accepting cycle
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			bus_q  <= alfb_pkg::ALFB_BUS_IDLE;
			wait_q <= 1'b1;
		end
		else
		begin
			bus_q  <= bus_d;
			wait_q <= (bus_d != alfb_pkg::ALFB_BUS_ACK);
		end
	end

	// line_control_word state
	logic [1:0] sel_q;
	logic [3:0] data_q;
	logic       stb_q;
	logic [3:0] line_q;
	logic [3:0] regsel_q;

	wire        lcw_wr   = wr_acc & hit_lcw & avs_byteenable[1];
	wire [1:0]  sel_wr   = avs_writedata[alfb_pkg::ALFB_LCW_SEL_LSB +: 2];
	wire [3:0]  data_wr  = avs_writedata[alfb_pkg::ALFB_LCW_DATA_LSB +: 4];
	wire        stb_wr   = avs_writedata[alfb_pkg::ALFB_LCW_STB_BIT];
	wire        ssw_wr0  = wr_acc & hit_ssw & avs_byteenable[0];
	wire        ssw_wr1  = wr_acc & hit_ssw & avs_byteenable[1];

	// data and code land with the strobe, so one write suffices
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			sel_q  <= 2'b00;
			data_q <= alfb_pkg::ALFB_RST_NIBBLE;
			stb_q  <= 1'b0;
		end
		else
		begin
			if (lcw_wr)
			begin
				sel_q  <= sel_wr;
				data_q <= data_wr;
			end
			stb_q <= lcw_wr & stb_wr;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			line_q   <= alfb_pkg::ALFB_RST_NIBBLE;
			regsel_q <= alfb_pkg::ALFB_RST_NIBBLE;
		end
		else
		begin
			if (ssw_wr0)
			begin
				line_q <= avs_writedata[alfb_pkg::ALFB_SSW_LINE_LSB +: 4];
			end
			if (ssw_wr1)
			begin
				regsel_q <= avs_writedata[alfb_pkg::ALFB_SSW_REG_LSB +: 4];
			end
		end
	end

	// load decode for the strobe cycle
	wire ld_fmt  = stb_q & (sel_q == alfb_pkg::ALFB_SEL_FORMAT);
	wire ld_spd  = stb_q & (sel_q == alfb_pkg::ALFB_SEL_SPEED);
	wire ld_pri  = stb_q & (sel_q == alfb_pkg::ALFB_SEL_PRIMARY);

	logic [3:0] fmt_q  [LINES];
	logic [3:0] spd_q  [LINES];
	logic       even_q [LINES];

	genvar gi;
	generate
		for (gi = 0; gi < LINES; gi++)
		begin : g_line
			wire                      here        = (line_q == 4'(gi));
			wire [3:0]                len_code    = {2'b00, fmt_q[gi][alfb_pkg::ALFB_FMT_LEN_LSB +: 2]};
			wire                      ld_fmt_here = ld_fmt & here;
			wire                      ld_spd_here = ld_spd & here;
			wire                      ld_pri_here = ld_pri & here;
			alfb_pkg::alfb_line_cfg_t cfg_d;

			// field decode of the stored nibbles
			assign cfg_d.data_bits   = len_code + 4'h5;
			assign cfg_d.stop_bits   = fmt_q[gi][alfb_pkg::ALFB_FMT_TWO_STOP] ? 2'h2 : 2'h1;
			assign cfg_d.parity_en   = fmt_q[gi][alfb_pkg::ALFB_FMT_PAR_EN];
			assign cfg_d.even_parity = even_q[gi];
			assign cfg_d.speed_code  = spd_q[gi];
			assign cfg_d.bit_cycles  = alfb_pkg::alfb_bit_cycles(spd_q[gi]);

			// only an addressed strobe changes a line's setting
			always_ff @(posedge ref_clk)
			begin
				if (!nrst)
				begin
					fmt_q[gi]  <= alfb_pkg::ALFB_RST_NIBBLE;
					spd_q[gi]  <= alfb_pkg::ALFB_RST_NIBBLE;
					even_q[gi] <= 1'b0;
				end
				else
				begin
					if (ld_fmt_here)
					begin
						fmt_q[gi] <= data_q;
					end
					if (ld_spd_here)
					begin
						spd_q[gi] <= data_q;
					end
					if (ld_pri_here)
					begin
						even_q[gi] <= data_q[alfb_pkg::ALFB_PRI_EVEN];
					end
				end
			end

			// registered decode keeps the cycle lookup off the output path
			always_ff @(posedge ref_clk)
			begin
				if (!nrst)
				begin
					line_cfg[gi] <= '0;
				end
				else
				begin
					line_cfg[gi] <= cfg_d;
				end
			end
		end
	endgenerate

	// status view of the selected line; out-of-range lines read zero
	wire        line_ok  = (32'(line_q) < 32'(LINES));
	wire [3:0]  line_ix  = line_ok ? line_q : 4'h0;
	wire [3:0]  sel_fmt  = line_ok ? fmt_q[line_ix] : 4'h0;
	wire [3:0]  sel_spd  = line_ok ? spd_q[line_ix] : 4'h0;
	wire        sel_even = line_ok ? even_q[line_ix] : 1'b0;

	wire [31:0] lcw_rd  = {16'h0000, 1'b0, data_q, sel_q, 9'h000};
	wire [31:0] ssw_rd  = {20'h00000, regsel_q, 4'h0, line_q};
	wire [31:0] stat_rd = {23'h000000, sel_even, sel_spd, sel_fmt};

	always_comb
	begin
		rdata_d = alfb_pkg::ALFB_RST_WORD;
		if (hit_lcw)
		begin
			rdata_d = lcw_rd;
		end
		else if (hit_ssw)
		begin
			rdata_d = ssw_rd;
		end
		else if (hit_stat)
		begin
			rdata_d = stat_rd;
		end
	end

	// captured while waitrequest is high, stable at the accepting edge
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
		begin
			rdata_q <= alfb_pkg::ALFB_RST_WORD;
		end
		else if (avs_read & (bus_q == alfb_pkg::ALFB_BUS_IDLE))
		begin
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;

endmodule : alfb_line_cfg

// >>> verification/alfb_line_cfg_asserts.sv
`timescale 1ns/100ps
module alfb_line_cfg_chk #(
	parameter int LINES = 16
) (
	input wire logic                                 ref_clk,
	input wire logic                                 nrst,
	input wire logic [3:0]                           avs_address,
	input wire logic                                 avs_read,
	input wire logic                                 avs_write,
	input wire logic [31:0]                          avs_writedata,
	input wire logic [3:0]                           avs_byteenable,
	input wire logic [31:0]                          avs_readdata,
	input wire logic                                 avs_waitrequest,
	input wire alfb_pkg::alfb_line_cfg_t [LINES-1:0] line_cfg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	logic [3:0] line_q;
	wire        wacc   = avs_write && !avs_waitrequest;
	wire        lcw_go = wacc && avs_address == 4'h0 && avs_writedata[15];
	wire        fmt_go = lcw_go && avs_writedata[10:9] == 2'b01;
	wire        spd_go = lcw_go && avs_writedata[10:9] == 2'b10;
	wire        pri_go = lcw_go && avs_writedata[10:9] == 2'b00;
	wire [3:0]  wnib   = avs_writedata[14:11];
	wire        wpar   = avs_writedata[14];
	wire [3:0]  wlen   = {2'b00, wnib[1:0]} + 4'd5;
	wire [1:0]  wstop  = wnib[2] ? 2'd2 : 2'd1;
	// line select is not visible at the ports, so shadow it
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			line_q <= 4'h0;
		else if (wacc && avs_address == 4'h4 && avs_byteenable[0])
			line_q <= avs_writedata[3:0];
	end
	a_fmt_len: assert property (fmt_go |-> ##3 line_cfg[line_q].data_bits == $past(wlen, 3))
		else $error("format length not applied");
	a_fmt_stop: assert property (fmt_go |-> ##3 line_cfg[line_q].stop_bits == $past(wstop, 3))
		else $error("stop bits not applied");
	a_fmt_par: assert property (fmt_go |-> ##3 line_cfg[line_q].parity_en == $past(wpar, 3))
		else $error("parity enable not applied");
	a_spd_load: assert property (spd_go |-> ##3 line_cfg[line_q].speed_code == $past(wnib, 3))
		else $error("speed code not applied");
	a_par_sense: assert property (pri_go |-> ##3 line_cfg[line_q].even_parity == $past(avs_writedata[12], 3))
		else $error("parity sense not applied");
	a_top_rate: assert property (spd_go && wnib == 4'hf |-> ##3 line_cfg[line_q].bit_cycles == 23'd6510)
		else $error("top rate wrong");
	a_strobe_clr: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0 |-> !avs_readdata[15])
		else $error("strobe bit reads one");
	// two past samples skip the edge where the reset defaults appear
	a_cfg_hold: assert property ($past(nrst) && $past(nrst, 2) && !$past(lcw_go, 3) |-> $stable(line_cfg))
		else $error("settings changed without strobe");
	a_rst_clear: assert property ($rose(nrst) |=> line_cfg[0].speed_code == 4'h0 && !line_cfg[0].parity_en)
		else $error("settings not cleared");
	c_fmt: cover property (fmt_go);
	c_top: cover property (spd_go && wnib == 4'hf);
	c_prim: cover property (lcw_go && avs_writedata[10:9] == 2'b00);
endmodule : alfb_line_cfg_chk

bind alfb_line_cfg alfb_line_cfg_chk #(.LINES(LINES)) alfb_line_cfg_chk_i (.ref_clk(ref_clk), .nrst(nrst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.line_cfg(line_cfg));

// >>> verification/alfb_term_model.sv
`timescale 1ns/100ps
module alfb_term_model (
	input wire alfb_pkg::alfb_line_cfg_t cfg,
	output logic [3:0]                   frame_bits
);
	// start, data, parity and stop bits the far terminal expects per character
	assign frame_bits = 4'd1 + cfg.data_bits + {3'b000, cfg.parity_en} + {2'b00, cfg.stop_bits};
endmodule : alfb_term_model

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
	logic                            ref_clk, nrst, avs_read, avs_write, avs_waitrequest;
	logic [3:0]                      avs_address, avs_byteenable, lsel, frame_bits;
	logic [31:0]                     avs_writedata, avs_readdata, rd, rnd;
	alfb_pkg::alfb_line_cfg_t [15:0] line_cfg;
	logic [3:0]                      ef [16] = '{default: 4'h0};
	logic [3:0]                      es [16] = '{default: 4'h0};
	logic                            ee [16] = '{default: 1'b0};
	int                              failures, checked;
	alfb_line_cfg alfb_line_cfg_i (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .line_cfg(line_cfg));
	alfb_term_model alfb_term_model_i (.cfg(line_cfg[lsel]), .frame_bits(frame_bits));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	function automatic logic [31:0] cyc(input logic [3:0] c);
		longint unsigned b;
		case (c)
			4'h0: b = 64'd500;
			4'h1: b = 64'd750;
			4'h2: b = 64'd1100;
			4'h3: b = 64'd1345;
			4'h4: b = 64'd1500;
			4'h5: b = 64'd3000;
			4'h6: b = 64'd6000;
			4'h7: b = 64'd12000;
			4'h8: b = 64'd18000;
			4'h9: b = 64'd20000;
			4'ha: b = 64'd24000;
			4'hb: b = 64'd36000;
			4'hc: b = 64'd48000;
			4'hd: b = 64'd72000;
			4'he: b = 64'd96000;
			default: b = 64'd384000;
		endcase
		// rate in tenths of a baud against 250 MHz, rounded to nearest
		return 32'((64'd2500000000 + b / 64'd2) / b);
	endfunction : cyc
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 50)
			failures++;
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : xfer
	task lcw(input logic [1:0] sel, input logic [3:0] nib, input logic stb);
		xfer(1'b1, 4'h0, {16'h0, stb, nib, sel, 9'h0});
	endtask : lcw
	task look(input int l);
		lsel = l[3:0];
		@(posedge ref_clk);
		chk(line_cfg[l].data_bits, 32'd5 + ef[l][1:0]);
		chk(line_cfg[l].stop_bits, ef[l][2] ? 32'd2 : 32'd1);
		chk(line_cfg[l].parity_en, ef[l][3]);
		chk(line_cfg[l].even_parity, ee[l]);
		chk(line_cfg[l].speed_code, es[l]);
		chk(line_cfg[l].bit_cycles, cyc(es[l]));
		chk(frame_bits, 32'd7 + ef[l][1:0] + ef[l][2] + ef[l][3]);
	endtask : look
	task report_and_stop;
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		repeat (4000) @(posedge ref_clk);
		failures++;
		report_and_stop;
	end
	initial
	begin
		nrst = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		lsel = 4'h0;
		rnd = 32'hd437;
		failures = 0;
		checked = 0;
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		xfer(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0);
		look(0);
		for (int l = 0; l < 16; l++)
		begin
			rnd = xs(rnd);
			ef[l] = rnd[3:0];
			ee[l] = rnd[4];
			es[l] = 4'(15 - l);
			xfer(1'b1, 4'h4, {28'h0, 4'(l)});
			lcw(2'b00, {2'b00, ee[l], 1'b0}, 1'b1);
			lcw(2'b01, ef[l], 1'b1);
			lcw(2'b10, es[l], 1'b1);
			xfer(1'b0, 4'h0, 32'h0);
			chk(rd[15:9], {1'b0, es[l], 2'b10});
			look(l);
		end
		lcw(2'b01, ~ef[15], 1'b0);
		lcw(2'b11, 4'hf, 1'b1);
		xfer(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		for (int l = 0; l < 16; l++)
			look(l);
		nrst <= 1'b0;
		@(posedge ref_clk);
		nrst <= 1'b1;
		ef[3] = 4'h0;
		es[3] = 4'h0;
		ee[3] = 1'b0;
		xfer(1'b0, 4'h0, 32'h0);
		chk(rd, 32'h0);
		look(3);
		report_and_stop;
	end
endmodule : tb
